// ==== usc_pkg.sv ====
// Package with register map, field positions and shared types of the serial port
package usc_pkg;
  // Register indices on the plain register port (byte addresses)
  localparam logic [2:0] ADDR_DATA   = 3'h0;
  localparam logic [2:0] ADDR_FRAME  = 3'h1;
  localparam logic [2:0] ADDR_CTRL   = 3'h2;
  localparam logic [2:0] ADDR_FLAGS  = 3'h3;
  localparam logic [2:0] ADDR_RATE   = 3'h4;

  // frame_config field positions
  localparam int FC_RX_NINE  = 7;
  localparam int FC_TX_NINE  = 6;
  localparam int FC_LEN9     = 4;
  localparam int FC_WAKE     = 3;

  // serial_control field positions
  localparam int SC_TXE_IE   = 7;
  localparam int SC_TXD_IE   = 6;
  localparam int SC_RX_IE    = 5;
  localparam int SC_IDLE_IE  = 4;
  localparam int SC_TX_EN    = 3;
  localparam int SC_RX_EN    = 2;
  localparam int SC_STANDBY  = 1;
  localparam int SC_BREAK    = 0;

  // serial_flags field positions
  localparam int SF_TX_EMPTY = 7;
  localparam int SF_TX_DONE  = 6;
  localparam int SF_RX_FULL  = 5;
  localparam int SF_IDLE     = 4;
  localparam int SF_OVERRUN  = 3;
  localparam int SF_NOISE    = 2;
  localparam int SF_FRAMING  = 1;

  // rate_select field positions
  localparam int RS_PRE_LSB  = 4;
  localparam int RS_DIV_LSB  = 0;

  // Reset values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [6:0] FLAGS_RESET = 7'h60;

  // Prescaler terminal counts (divide minus one)
  localparam logic [3:0] PRE_DIV1  = 4'h0;
  localparam logic [3:0] PRE_DIV3  = 4'h2;
  localparam logic [3:0] PRE_DIV4  = 4'h3;
  localparam logic [3:0] PRE_DIV13 = 4'hC;

  // Oversampling and frame lengths
  localparam logic [3:0] SUB_LAST   = 4'hF;
  localparam logic [3:0] SAMPLE_A   = 4'h7;
  localparam logic [3:0] SAMPLE_B   = 4'h8;
  localparam logic [3:0] SAMPLE_C   = 4'h9;
  localparam logic [3:0] FRAME_LEN8 = 4'hA;
  localparam logic [3:0] FRAME_LEN9 = 4'hB;
  localparam logic [3:0] ONE_BIT    = 4'h1;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } usc_req_t;

  // Transmit states
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01
  } usc_tx_state_t;

  // Receive states
  typedef enum logic [1:0] {
    RX_WAIT  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10
  } usc_rx_state_t;
endpackage

// ==== usc_top.sv ====
// Serial port control, status, rate generator, transmitter and receiver
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Behaviour
// - In 9-bit mode ninth received bit stored with data; reset keeps it
// - In 9-bit mode ninth transmit bit loaded with data; reset keeps it
// - Length bit 1 gives 9-bit characters, 0 gives 8-bit; reset keeps
// - Wake bit 1 wakes on address mark, 0 on idle line; reset keeps
// - Interrupt while transmit-empty flag and its enable set; reset clears
// - Interrupt while transmit-done flag and its enable set; reset clears
// - Interrupt on receive-full or overrun with enable set; reset clears
// - Interrupt while idle flag and its enable set; reset clears enable
// - Transmit enable starts with a preamble of 10 or 11 ones
// - Receive enable gates receiver and its interrupts; flags are kept
// - Standby bit set by software, cleared by hardware on wakeup
// - Send break emits groups of zeros, then a one when cleared
// - Transmit-empty set on load; cleared by status read then data write
// - Transmit-done set when empty and idle; same clear; reset sets
// - Receive-full set on transfer; status read then data read clears
// - Idle flag set after 10 or 11 ones; status read then data read
// - Overrun keeps old data, drops new; status read then data read
// - Noise flag with the character; status read then data read
// - Framing error on zero stop bit; overrun has priority
// - Prescaler divides by 1, 3, 4 or 13; reset clears select
// - Rate select divides by 1 to 128; reset keeps it
// - Transmit frame: start 0 first, stop 1 last
// - Sixteen samples per bit; noise set with receive-full
module usc_top (
  input  wire logic            I_CLOCK, // 200 MHz clock
  input  wire logic            I_RST,   // Synchronous reset, high
  input  wire usc_pkg::usc_req_t i_bus, // Register port request
  output logic [7:0]           o_rdata, // Read data, cycle after read
  input  wire logic            i_rx_pin, // Serial receive pin
  output logic                 o_tx_pin, // Serial transmit pin level
  output logic                 o_tx_oe,  // Transmit pin driven
  output logic                 o_irq     // Combined interrupt request
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0] tx_data;
  logic [7:0] rx_data;
  logic       rx_bit_nine, tx_bit_nine, len9, wake;
  logic [7:0] ctrl;
  logic [1:0] pre_sel;
  logic [2:0] rate_div_sel;
  logic       tx_empty_flag, tx_done_flag, rx_full_flag, idle_flag;
  logic       overrun_flag, noise_flag, framing_err_flag;
  logic [6:0] armed;
  logic [6:0] flags;
  logic       wr_data, rd_data, rd_flags;
  logic [3:0] pre_cnt;
  logic [6:0] rate_cnt;
  logic       tick;
  logic [2:0] rx_sync;
  logic       rx_level;
  logic       te_q, preamble_req, break_tail;
  usc_pkg::usc_tx_state_t tx_state;
  logic [10:0] tx_sh;
  logic [3:0]  tx_bits, tx_sub;
  logic        tx_boundary, tx_active;
  usc_pkg::usc_rx_state_t rx_state;
  logic [3:0]  rx_sub, rx_bit;
  logic [8:0]  rx_sh;
  logic [2:0]  smp;
  logic        rx_noisy, rx_done, rx_stop_ok, rx_mark;
  logic [7:0]  idle_cnt_bits;
  logic [3:0]  idle_sub;
  logic        idle_armed, idle_event;
  logic [3:0]  frame_len;

  // Terminal count of the prescaler for a select code
  function automatic logic [3:0] pre_limit(input logic [1:0] sel);
    case (sel)
      2'b00:   pre_limit = usc_pkg::PRE_DIV1;
      2'b01:   pre_limit = usc_pkg::PRE_DIV3;
      2'b10:   pre_limit = usc_pkg::PRE_DIV4;
      default: pre_limit = usc_pkg::PRE_DIV13;
    endcase
  endfunction

  // Majority of three samples
  function automatic logic maj3(input logic [2:0] s);
    maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Access decode
  assign wr_data  = i_bus.wr && (i_bus.addr == usc_pkg::ADDR_DATA);
  assign rd_data  = i_bus.rd && (i_bus.addr == usc_pkg::ADDR_DATA);
  assign rd_flags = i_bus.rd && (i_bus.addr == usc_pkg::ADDR_FLAGS);
  assign frame_len = len9 ? usc_pkg::FRAME_LEN9 : usc_pkg::FRAME_LEN8;
  assign flags = {tx_empty_flag, tx_done_flag, rx_full_flag, idle_flag,
                  overrun_flag, noise_flag, framing_err_flag};

  // Register writes of the control fields
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      ctrl    <= usc_pkg::CTRL_RESET;
      pre_sel <= 2'h0;
    end else begin
      if (i_bus.wr && i_bus.addr == usc_pkg::ADDR_CTRL) begin
        ctrl <= i_bus.wdata;
      end
      if (i_bus.wr && i_bus.addr == usc_pkg::ADDR_RATE) begin
        pre_sel <= i_bus.wdata[usc_pkg::RS_PRE_LSB +: 2];
      end
      // Hardware wakeup wins over a write in the same cycle
      if (ctrl[usc_pkg::SC_STANDBY] &&
          ((!wake && idle_event) || (wake && rx_done && rx_mark))) begin
        ctrl[usc_pkg::SC_STANDBY] <= 1'b0;
      end
    end
  end

  // Fields that reset leaves untouched
  always_ff @(posedge I_CLOCK) begin
    if (i_bus.wr && i_bus.addr == usc_pkg::ADDR_FRAME) begin
      tx_bit_nine <= i_bus.wdata[usc_pkg::FC_TX_NINE];
      len9        <= i_bus.wdata[usc_pkg::FC_LEN9];
      wake        <= i_bus.wdata[usc_pkg::FC_WAKE];
    end
    if (i_bus.wr && i_bus.addr == usc_pkg::ADDR_RATE) begin
      rate_div_sel <= i_bus.wdata[usc_pkg::RS_DIV_LSB +: 3];
    end
    if (wr_data) begin
      tx_data <= i_bus.wdata;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      o_rdata <= 8'h00;
    end else if (i_bus.rd) begin
      case (i_bus.addr)
        usc_pkg::ADDR_DATA:  o_rdata <= rx_data;
        usc_pkg::ADDR_FRAME: o_rdata <= {rx_bit_nine, tx_bit_nine, 1'b0,
                                         len9, wake, 3'h0};
        usc_pkg::ADDR_CTRL:  o_rdata <= ctrl;
        usc_pkg::ADDR_FLAGS: o_rdata <= {flags, 1'b0};
        usc_pkg::ADDR_RATE:  o_rdata <= {2'h0, pre_sel, 1'b0, rate_div_sel};
        default:             o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Rate generator: prescaler then power-of-two divider
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      pre_cnt  <= 4'h0;
      rate_cnt <= 7'h00;
      tick     <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (pre_cnt >= pre_limit(pre_sel)) begin
        pre_cnt <= 4'h0;
        if (rate_cnt >= 7'((8'h01 << rate_div_sel) - 8'h01)) begin
          rate_cnt <= 7'h00;
          tick     <= 1'b1;
        end else begin
          rate_cnt <= rate_cnt + 7'h01;
        end
      end else begin
        pre_cnt <= pre_cnt + 4'h1;
      end
    end
  end

  // Receive pin synchroniser; level moves when stages two and three agree
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      rx_sync  <= 3'h7;
      rx_level <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], i_rx_pin};
      if (rx_sync[1] == rx_sync[2]) begin
        rx_level <= rx_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter
  assign tx_boundary = tick && (tx_state == usc_pkg::TX_IDLE ||
                       (tx_sub == usc_pkg::SUB_LAST && tx_bits == 4'h1));
  assign tx_active   = (tx_state == usc_pkg::TX_SHIFT);

  // Frame sequencing, break and preamble handling
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      tx_state     <= usc_pkg::TX_IDLE;
      tx_sh        <= 11'h7FF;
      tx_bits      <= 4'h0;
      tx_sub       <= 4'h0;
      te_q         <= 1'b0;
      preamble_req <= 1'b0;
      break_tail   <= 1'b0;
    end else begin
      te_q <= ctrl[usc_pkg::SC_TX_EN];
      if (ctrl[usc_pkg::SC_TX_EN] && !te_q) begin
        preamble_req <= 1'b1;
      end
      if (tx_boundary) begin
        tx_sub <= 4'h0;
        // An enable rising in this very cycle already counts as pending
        if (ctrl[usc_pkg::SC_TX_EN] && (preamble_req || !te_q)) begin
          tx_state     <= usc_pkg::TX_SHIFT;
          tx_sh        <= 11'h7FF;
          tx_bits      <= frame_len;
          preamble_req <= 1'b0;
        end else if (ctrl[usc_pkg::SC_TX_EN] && ctrl[usc_pkg::SC_BREAK]) begin
          tx_state   <= usc_pkg::TX_SHIFT;
          tx_sh      <= 11'h000;
          tx_bits    <= frame_len;
          break_tail <= 1'b1;
        end else if (break_tail) begin
          tx_state   <= usc_pkg::TX_SHIFT;
          tx_sh      <= 11'h7FF;
          tx_bits    <= usc_pkg::ONE_BIT;
          break_tail <= 1'b0;
        end else if (ctrl[usc_pkg::SC_TX_EN] && !tx_empty_flag) begin
          tx_state <= usc_pkg::TX_SHIFT;
          tx_bits  <= frame_len;
          if (len9) begin
            tx_sh <= {1'b1, tx_bit_nine, tx_data, 1'b0};
          end else begin
            tx_sh <= {2'b11, tx_data, 1'b0};
          end
        end else begin
          tx_state <= usc_pkg::TX_IDLE;
          tx_sh    <= 11'h7FF;
          tx_bits  <= 4'h0;
        end
      end else if (tick && tx_active) begin
        tx_sub <= tx_sub + 4'h1;
        if (tx_sub == usc_pkg::SUB_LAST) begin
          tx_sh   <= {1'b1, tx_sh[10:1]};
          tx_bits <= tx_bits - 4'h1;
        end
      end
    end
  end

  assign o_tx_pin = tx_sh[0];
  assign o_tx_oe  = ctrl[usc_pkg::SC_TX_EN] || tx_active || break_tail;

  ////////////////////////////////////////////////////////////////////////
  // Receiver: sixteen samples per bit, majority of the middle three
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      rx_state <= usc_pkg::RX_WAIT;
      rx_sub   <= 4'h0;
      rx_bit   <= 4'h0;
      rx_sh    <= 9'h000;
      smp      <= 3'h7;
      rx_noisy <= 1'b0;
      rx_done  <= 1'b0;
      rx_stop_ok <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!ctrl[usc_pkg::SC_RX_EN]) begin
        rx_state <= usc_pkg::RX_WAIT;
      end else if (tick) begin
        rx_sub <= rx_sub + 4'h1;
        if (rx_sub == usc_pkg::SAMPLE_A) smp[0] <= rx_level;
        if (rx_sub == usc_pkg::SAMPLE_B) smp[1] <= rx_level;
        if (rx_sub == usc_pkg::SAMPLE_C) smp[2] <= rx_level;
        case (rx_state)
          usc_pkg::RX_WAIT: begin
            rx_sub <= 4'h0;
            if (!rx_level) begin
              rx_state <= usc_pkg::RX_START;
              rx_noisy <= 1'b0;
            end
          end
          usc_pkg::RX_START: begin
            // Start bit must still be low at one of the first two centre samples
            if (rx_sub == usc_pkg::SAMPLE_B && rx_level && smp[0]) begin
              rx_state <= usc_pkg::RX_WAIT;
            end else if (rx_sub == usc_pkg::SUB_LAST) begin
              if (smp[0] != smp[1] || smp[1] != smp[2]) begin
                rx_noisy <= 1'b1;
              end
              rx_state <= usc_pkg::RX_BITS;
              rx_bit   <= 4'h1;
            end
          end
          usc_pkg::RX_BITS: begin
            if (rx_sub == usc_pkg::SUB_LAST) begin
              if (smp[0] != smp[1] || smp[1] != smp[2]) begin
                rx_noisy <= 1'b1;
              end
              rx_bit <= rx_bit + 4'h1;
              if (rx_bit == frame_len - 4'h1) begin
                rx_stop_ok <= maj3(smp);
                rx_done    <= 1'b1;
                rx_state   <= usc_pkg::RX_WAIT;
              end else begin
                rx_sh[rx_bit - 4'h1] <= maj3(smp);
              end
            end
          end
          default: rx_state <= usc_pkg::RX_WAIT;
        endcase
      end
    end
  end

  // Most significant bit of the character marks an address
  assign rx_mark = len9 ? rx_sh[8] : rx_sh[7];

  // Idle line detector: a full frame of ones after activity or after reset
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      idle_cnt_bits <= 8'h00;
      idle_sub      <= 4'h0;
      idle_armed    <= 1'b1;
      idle_event    <= 1'b0;
    end else begin
      idle_event <= 1'b0;
      if (!ctrl[usc_pkg::SC_RX_EN] || !rx_level) begin
        idle_cnt_bits <= 8'h00;
        idle_sub      <= 4'h0;
        if (!rx_level) idle_armed <= 1'b1;
      end else if (tick) begin
        idle_sub <= idle_sub + 4'h1;
        if (idle_sub == usc_pkg::SUB_LAST) begin
          idle_cnt_bits <= idle_cnt_bits + 8'h01;
          if (idle_cnt_bits == {4'h0, frame_len} - 8'h01 && idle_armed) begin
            idle_event <= 1'b1;
            idle_armed <= 1'b0;
          end
        end
      end
    end
  end

  // Receive data buffer and ninth bit; reset leaves them as they are
  always_ff @(posedge I_CLOCK) begin
    if (rx_done && !rx_full_flag && (!ctrl[usc_pkg::SC_STANDBY] ||
        (wake && rx_mark))) begin
      rx_data     <= rx_sh[7:0];
      rx_bit_nine <= rx_sh[8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags; a hardware set wins over a clear in the same cycle
  logic accept_rx;
  assign accept_rx = rx_done && (!ctrl[usc_pkg::SC_STANDBY] ||
                     (wake && rx_mark));

  // Flags seen set by a status read arm the later data access clear
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      armed <= 7'h00;
    end else if (rd_flags) begin
      armed <= flags;
    end else if (wr_data) begin
      armed[6:5] <= 2'b00;
    end else if (rd_data) begin
      armed[4:0] <= 5'h00;
    end
  end

  // Transmit flags
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      tx_empty_flag <= usc_pkg::FLAGS_RESET[6];
      tx_done_flag  <= usc_pkg::FLAGS_RESET[5];
    end else begin
      if (tx_boundary && ctrl[usc_pkg::SC_TX_EN] && te_q && !preamble_req &&
          !ctrl[usc_pkg::SC_BREAK] && !break_tail && !tx_empty_flag) begin
        tx_empty_flag <= 1'b1;
      end else if (wr_data && armed[6]) begin
        tx_empty_flag <= 1'b0;
      end
      if (tx_empty_flag && !tx_active && !preamble_req && !break_tail &&
          !ctrl[usc_pkg::SC_BREAK]) begin
        tx_done_flag <= 1'b1;
      end else if (wr_data && armed[5]) begin
        tx_done_flag <= 1'b0;
      end else if (tx_active) begin
        tx_done_flag <= 1'b0;
      end
    end
  end

  // Receive flags
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      rx_full_flag     <= 1'b0;
      idle_flag        <= 1'b0;
      overrun_flag     <= 1'b0;
      noise_flag       <= 1'b0;
      framing_err_flag <= 1'b0;
    end else begin
      if (accept_rx && !rx_full_flag) begin
        rx_full_flag     <= 1'b1;
        noise_flag       <= rx_noisy;
        framing_err_flag <= !rx_stop_ok;
      end else if (rd_data) begin
        if (armed[4]) rx_full_flag     <= 1'b0;
        if (armed[1]) noise_flag       <= 1'b0;
        if (armed[0]) framing_err_flag <= 1'b0;
      end
      if (accept_rx && rx_full_flag) begin
        overrun_flag <= 1'b1;
      end else if (rd_data && armed[2]) begin
        overrun_flag <= 1'b0;
      end
      if (idle_event && !ctrl[usc_pkg::SC_STANDBY]) begin
        idle_flag <= 1'b1;
      end else if (rd_data && armed[3]) begin
        idle_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt request; receiver sources gated by enable and standby
  logic rx_irq_ok;
  assign rx_irq_ok = ctrl[usc_pkg::SC_RX_EN] && !ctrl[usc_pkg::SC_STANDBY];
  assign o_irq =
      (tx_empty_flag && ctrl[usc_pkg::SC_TXE_IE])
    | (tx_done_flag && ctrl[usc_pkg::SC_TXD_IE])
    | (rx_irq_ok && ctrl[usc_pkg::SC_RX_IE] &&
       (rx_full_flag || overrun_flag))
    | (rx_irq_ok && ctrl[usc_pkg::SC_IDLE_IE] && idle_flag);

endmodule

// ==== usc_top_asserts.sv ====
// Port-level assertions for the serial port block
`timescale 1ns/1ps
module usc_top_asserts (
  input wire logic              I_CLOCK,  // Clock
  input wire logic              I_RST,    // Reset
  input wire usc_pkg::usc_req_t i_bus,    // Register request
  input wire logic [7:0]        o_rdata,  // Read data
  input wire logic              i_rx_pin, // Receive pin
  input wire logic              o_tx_pin, // Transmit pin
  input wire logic              o_tx_oe,  // Transmit drive
  input wire logic              o_irq     // Interrupt
);
  logic [7:0] ctrl;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  ////////////////////////////////////////////////////////////////////////
  // Control register as seen from bus writes
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      ctrl <= 8'h00;
    end else if (i_bus.wr && i_bus.addr == usc_pkg::ADDR_CTRL) begin
      ctrl <= i_bus.wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  property p_rd_idle;
    !$past(i_bus.rd) |-> o_rdata == 8'h00;
  endproperty
  property p_unmapped;
    i_bus.rd && i_bus.addr > 3'h4 |=> o_rdata == 8'h00;
  endproperty
  property p_reset_out;
    $past(I_RST) |-> o_tx_pin && !o_tx_oe && !o_irq;
  endproperty
  property p_irq_en;
    o_irq |-> ctrl[7:4] != 4'h0;
  endproperty
  property p_irq_rx;
    o_irq && !ctrl[7] && !ctrl[6] |-> ctrl[2];
  endproperty
  property p_oe;
    ctrl[3] && $past(ctrl[3]) |-> o_tx_oe;
  endproperty
  property p_preamble;
    $rose(ctrl[3]) && !ctrl[0] |-> o_tx_pin [*8];
  endproperty
  property p_break_low;
    $fell(o_tx_pin) && ctrl[0] |=> !o_tx_pin [*8];
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside read cycle");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_reset_out: assert property (p_reset_out)
    else $error("outputs wrong after reset");
  a_irq_en: assert property (p_irq_en)
    else $error("interrupt with all enables clear");
  a_irq_rx: assert property (p_irq_rx)
    else $error("receive interrupt with receiver off");
  a_oe: assert property (p_oe)
    else $error("pin not driven while transmitter on");
  a_preamble: assert property (p_preamble)
    else $error("preamble not ones");
  a_break_low: assert property (p_break_low)
    else $error("break not held low");
  c_irq: cover property (o_irq);
  c_break: cover property (ctrl[0] && !o_tx_pin);
  c_rx: cover property (!i_rx_pin && ctrl[2]);
endmodule

bind usc_top usc_top_asserts i_usc_top_asserts (
  .I_CLOCK(I_CLOCK), .I_RST(I_RST), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_rx_pin(i_rx_pin), .o_tx_pin(o_tx_pin), .o_tx_oe(o_tx_oe), .o_irq(o_irq)
);

// ==== usc_remote.sv ====
// Behavioural remote transceiver on the serial lines
`timescale 1ns/1ps
module usc_remote (
  input  wire logic clk,     // Clock
  input  wire logic tx_line, // Line from the block
  output logic      rx_line  // Line to the block
);
  int          bit_clks = 16;
  int          rx_bits = 11;
  int          got_cnt = 0;
  logic [10:0] got = 11'h000;
  initial rx_line = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // Send n bits LSB first, line back to idle mark after
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_line <= bits[i];
      repeat (bit_clks - 1) @(posedge clk);
    end
    @(posedge clk);
    rx_line <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Receiver: start bit first, sampled at bit centre
  initial begin
    forever begin
      @(posedge clk);
      if (tx_line === 1'b0) begin
        repeat (bit_clks / 2) @(posedge clk);
        got[0] = tx_line;
        for (int i = 1; i < rx_bits; i++) begin
          repeat (bit_clks) @(posedge clk);
          got[i] = tx_line;
        end
        got_cnt++;
      end
    end
  end
endmodule

// ==== tb_usc_top.sv ====
// Self-checking testbench for the serial port block
`timescale 1ns/1ps
module tb_usc_top;
  localparam logic [2:0] A_DA = usc_pkg::ADDR_DATA;
  localparam logic [2:0] A_FR = usc_pkg::ADDR_FRAME;
  localparam logic [2:0] A_CT = usc_pkg::ADDR_CTRL;
  localparam logic [2:0] A_FL = usc_pkg::ADDR_FLAGS;
  localparam logic [2:0] A_RT = usc_pkg::ADDR_RATE;
  logic              I_CLOCK = 1'b0;
  logic              I_RST = 1'b1;
  usc_pkg::usc_req_t bus = '0;
  logic [7:0]        rdata;
  logic              rx;
  logic              tx;
  logic              oe;
  logic              irq;
  logic [7:0]        d;
  int                fail_count = 0;
  int                num_checks = 0;
  always #2.5 I_CLOCK = ~I_CLOCK;
  usc_top i_usc_top (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .i_bus(bus),
    .o_rdata(rdata), .i_rx_pin(rx), .o_tx_pin(tx), .o_tx_oe(oe), .o_irq(irq));
  usc_remote i_usc_remote (.clk(I_CLOCK), .tx_line(tx), .rx_line(rx));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [11:0] seen, logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] v);
    @(posedge I_CLOCK);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge I_CLOCK);
    bus.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [2:0] a);
    @(posedge I_CLOCK);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge I_CLOCK);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic poll(logic [2:0] a, int b, logic v);
    for (int n = 0; n < 10000; n++) begin
      rd(a);
      if (d[b] === v) return;
    end
    check("poll bound", 11'h001, 11'h000);
    close_out();
  endtask
  task automatic waitpin(logic v);
    for (int n = 0; n < 5000; n++) begin
      @(posedge I_CLOCK);
      #1;
      if (tx === v) return;
    end
    check("pin bound", 11'h001, 11'h000);
    close_out();
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check("tx pin", tx, 11'h001);
    check("oe", oe, 11'h000);
    check("irq", irq, 11'h000);
    rd(A_CT);
    check("ctrl", d, 11'h000);
    rd(A_FL);
    check("flags", d, {usc_pkg::FLAGS_RESET, 1'b0});
    rd(A_RT);
    check("prescale", d[5:4], 11'h000);
    wr(3'h5, 8'hFF);
    rd(3'h5);
    check("unmapped", d, 11'h000);
  endtask
  task automatic t_tx();
    wr(A_RT, 8'h00);
    wr(A_FR, 8'h50);
    wr(A_CT, 8'h08);
    rd(A_FL);
    wr(A_DA, 8'hA5);
    rd(A_FL);
    check("tx done", d[6], 11'h000);
    poll(A_FL, 6, 1'b1);
    check("frame", i_usc_remote.got, 11'h74A);
    check("tx empty", d[7], 11'h001);
    wr(A_CT, 8'h48);
    check("irq done", irq, 11'h001);
    wr(A_CT, 8'h88);
    check("irq empty", irq, 11'h001);
  endtask
  task automatic t_rx();
    wr(A_FR, 8'h10);
    wr(A_CT, 8'h24);
    i_usc_remote.send(11'h678, 11);
    poll(A_FL, 5, 1'b1);
    check("irq rx", irq, 11'h001);
    check("noise", d[2:1], 11'h000);
    rd(A_DA);
    check("rx data", d, 11'h03C);
    rd(A_FR);
    check("bit nine", d[7], 11'h001);
    rd(A_FL);
    check("rx full", d[5], 11'h000);
  endtask
  task automatic t_err();
    wr(A_FR, 8'h00);
    i_usc_remote.send(11'h222, 10);
    poll(A_FL, 5, 1'b1);
    i_usc_remote.send(11'h044, 10);
    poll(A_FL, 3, 1'b1);
    check("or fe", d[3:1], 11'h004);
    check("irq or", irq, 11'h001);
    rd(A_DA);
    check("kept", d, 11'h011);
    i_usc_remote.send(11'h066, 10);
    poll(A_FL, 5, 1'b1);
    check("framing", d[3:1], 11'h001);
    rd(A_DA);
    check("fe data", d, 11'h033);
  endtask
  task automatic t_idle();
    poll(A_FL, 4, 1'b1);
    wr(A_CT, 8'h14);
    check("irq idle", irq, 11'h001);
    wr(A_CT, 8'h10);
    check("irq off", irq, 11'h000);
    rd(A_FL);
    check("idle kept", d[4], 11'h001);
  endtask
  task automatic t_wake();
    wr(A_FR, 8'h08);
    wr(A_CT, 8'h06);
    i_usc_remote.send(11'h2FE, 10);
    repeat (200) @(posedge I_CLOCK);
    rd(A_CT);
    check("standby", d[1], 11'h001);
    i_usc_remote.send(11'h300, 10);
    poll(A_CT, 1, 1'b0);
    poll(A_FL, 5, 1'b1);
    rd(A_DA);
    check("mark data", d, 11'h080);
    wr(A_FR, 8'h00);
    wr(A_CT, 8'h06);
    i_usc_remote.send(11'h2FE, 10);
    poll(A_CT, 1, 1'b0);
    rd(A_FL);
    check("dropped", d[5], 11'h000);
  endtask
  task automatic t_break();
    wr(A_CT, 8'h09);
    waitpin(1'b0);
    repeat (150) @(posedge I_CLOCK);
    #1;
    check("break", tx, 11'h000);
    wr(A_CT, 8'h08);
    waitpin(1'b1);
    poll(A_FL, 6, 1'b1);
  endtask
  task automatic t_rate();
    logic [7:0] cfg [4] = '{8'h07, 8'h11, 8'h23, 8'h32};
    int         exp [4] = '{2048, 96, 512, 832};
    int         n;
    for (int i = 0; i < 4; i++) begin
      wr(A_RT, cfg[i]);
      rd(A_FL);
      wr(A_DA, 8'h01);
      waitpin(1'b0);
      n = 0;
      while (tx === 1'b0 && n < 4000) begin
        @(posedge I_CLOCK);
        #1;
        n++;
      end
      check("bit time", 12'(n), 12'(exp[i]));
      poll(A_FL, 6, 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reset, then scenarios in order
  initial begin
    repeat (12) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    #1;
    t_reset();
    t_tx();
    t_rx();
    t_err();
    t_idle();
    t_wake();
    t_break();
    t_rate();
    close_out();
  end
endmodule
